/* stepper_pkg.sv */
// constants and types shared by the stepping motor sequencer and its pattern fifo
// assumes a single 100 MHz clock and an asynchronous active-high reset
`default_nettype none

package stepper_pkg;

  // ==========================================================
  // clock and step timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;                          // one interval unit is 1 us
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ==========================================================
  // widths and depths
  localparam int PHASE_W = 4;
  localparam int PHASE_DEPTH = 8;
  localparam int PHASE_AW = 3;
  localparam int IVL_W = 16;
  localparam int IVL_DEPTH = 16;
  localparam int IVL_AW = 4;
  localparam int LEN_W = 5;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // table contents and reset values
  typedef logic [PHASE_W-1:0] phase_t;
  localparam phase_t TWO_PHASE_TBL [PHASE_DEPTH] = '{4'h3, 4'h9, 4'hC, 4'h6, 4'h3, 4'h9, 4'hC, 4'h6};
  localparam phase_t HALF_STEP_TBL [PHASE_DEPTH] = '{4'h3, 4'h1, 4'h9, 4'h8, 4'hC, 4'h4, 4'h6, 4'h2};
  localparam phase_t PHASE_OUT_RESET = 4'h0;
  localparam logic [IVL_W-1:0] IVL_RESET = 16'h0010;
  localparam logic TBL_PHASE = 1'b0;
  localparam logic TBL_IVL = 1'b1;

  // ==========================================================
  // run states, gray along idle -> ramp -> cruise
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_CRUISE = 2'b11
  } run_state_t;

endpackage

`default_nettype wire

/* fifo_if.sv */
// handshake bundle between the sequencer and its pattern fifo
// assumes both ends run on the same clock
`default_nettype none

interface fifo_if #(parameter int WIDTH = 4);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic flush;

  // ==========================================================
  // fifo side and user side
  modport store (input push_valid, input push_data, input pop_ready, input flush,
                 output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready, output flush,
                input push_ready, input pop_valid, input pop_data);
endinterface

`default_nettype wire

/* step_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush
// assumes DEPTH is a power of two; memory itself is not reset
`default_nettype none

module step_fifo import stepper_pkg::*; #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data path
  fifo_if.store port
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic full, empty, push, pop;

  // ==========================================================
  // flags: extra pointer bit tells full from empty
  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign push = port.push_valid && !full;
  assign pop = port.pop_ready && !empty;
  assign port.push_ready = !full;
  assign port.pop_valid = !empty;
  assign port.pop_data = mem[rd_reg[AW-1:0]];

  // pointer update; flush drops everything, a push in that cycle is lost too
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (port.flush) begin
      wr_next = '0;
      rd_next = '0;
    end else begin
      if (push) wr_next = wr_reg + (AW+1)'(1);
      if (pop) rd_next = rd_reg + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push && !port.flush) mem[wr_reg[AW-1:0]] <= port.push_data;
  end

endmodule

`default_nettype wire

/* stepper_ramp_phase_sequencer.sv */
// four-phase stepping motor sequencer with a table-driven slow-up ramp; a stop ends the run at once, with no slow-down
// assumes synchronous control inputs on REF_CLK (100 MHz) and an asynchronous reset
// tables and run control come in on pins; the block has no software-visible registers
//
// Operation
// - phase channel copies table patterns into the pulse output data, one per step
// - interval channel copies table intervals into the step timer count register
// - completion pulse raised by the interval channel when the ramp ends
// - pulse output unit in mode 0 presents each new pattern on the pins
// - after the ramp the motor keeps stepping at the last, constant interval
// - 4-bit patterns; two-phase 3,9,C,6 repeated; half-step 3,1,9,8,C,4,6,2
`default_nettype none

module stepper_ramp_phase_sequencer import stepper_pkg::*; (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // run control
  input wire logic START,
  input wire logic STOP,
  input wire logic [LEN_W-1:0] RAMP_LEN,
  // table loading
  input wire logic PRESET,
  input wire logic HALF_STEP,
  input wire logic TBL_WR,
  input wire logic TBL_SEL,
  input wire logic [IVL_AW-1:0] TBL_ADDR,
  input wire logic [IVL_W-1:0] TBL_DATA,
  // motor phase pins
  output logic [PHASE_W-1:0] PHASE_OUT,
  // status
  output logic STEP_PULSE,
  output logic RAMP_DONE,
  output logic RUNNING,
  output logic CRUISING,
  output logic UNDERRUN,
  output logic [15:0] STEP_COUNT
);

  // ==========================================================
  // state
  run_state_t state_reg, state_next;
  phase_t phase_mem_reg [PHASE_DEPTH];
  phase_t phase_mem_next [PHASE_DEPTH];
  logic [IVL_W-1:0] ivl_mem_reg [IVL_DEPTH];
  logic [IVL_W-1:0] ivl_mem_next [IVL_DEPTH];
  logic [IVL_W-1:0] ivl_reg, ivl_next;
  logic [IVL_W-1:0] count_reg, count_next;
  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [LEN_W-1:0] idx_reg, idx_next;
  logic [PHASE_AW-1:0] ptr_reg, ptr_next;
  phase_t phase_out_reg, phase_out_next;
  logic step_reg, step_next;
  logic done_reg, done_next;
  logic under_reg, under_next;
  logic [15:0] steps_reg, steps_next;
  logic tick, expiry, running;
  logic [LEN_W-1:0] last_idx;
  logic [IVL_W-1:0] ivl_fetch;
  // channel decisions shared by the groups below
  logic take_start, load_ivl, ramp_end;

  // handshake bundle to the pattern fifo
  fifo_if #(.WIDTH(PHASE_W)) ph_if ();

  // ==========================================================
  // pattern fifo between the phase channel and the pulse output unit
  step_fifo #(.WIDTH(PHASE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .port(ph_if.store)
  );

  // ==========================================================
  // timer and channel strobes
  assign running = (state_reg != ST_IDLE);
  assign tick = running && (tick_reg == '0);
  // an interval of 0 behaves as 1 so the timer can never stall
  assign expiry = tick && (count_reg <= IVL_W'(1));
  assign last_idx = (RAMP_LEN == '0) ? '0 : RAMP_LEN - LEN_W'(1);
  assign ivl_fetch = ivl_mem_reg[idx_reg[IVL_AW-1:0]];

  // phase channel fills ahead; a full fifo stalls it, only steps and flushes drain it
  assign ph_if.push_valid = running;
  assign ph_if.push_data = phase_mem_reg[ptr_reg];
  assign ph_if.pop_ready = expiry;
  assign ph_if.flush = !running || START || STOP;

  // ==========================================================
  // phase table: preset wins over a write in the same cycle
  always_comb begin
    for (int i = 0; i < PHASE_DEPTH; i++) begin
      phase_mem_next[i] = phase_mem_reg[i];
    end
    if (PRESET) begin
      for (int i = 0; i < PHASE_DEPTH; i++) begin
        phase_mem_next[i] = HALF_STEP ? HALF_STEP_TBL[i] : TWO_PHASE_TBL[i];
      end
    end else if (TBL_WR && (TBL_SEL == TBL_PHASE)) begin
      phase_mem_next[TBL_ADDR[PHASE_AW-1:0]] = TBL_DATA[PHASE_W-1:0];
    end
  end

  // reset loads the two-phase set so a start straight after reset still turns the motor
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < PHASE_DEPTH; i++) begin
        phase_mem_reg[i] <= TWO_PHASE_TBL[i];
      end
    end else begin
      phase_mem_reg <= phase_mem_next;
    end
  end

  // interval table: a write in a preset cycle is dropped here too, like the phase table
  always_comb begin
    for (int i = 0; i < IVL_DEPTH; i++) begin
      ivl_mem_next[i] = ivl_mem_reg[i];
    end
    if (!PRESET && TBL_WR && (TBL_SEL == TBL_IVL)) begin
      ivl_mem_next[TBL_ADDR] = TBL_DATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < IVL_DEPTH; i++) begin
        ivl_mem_reg[i] <= IVL_RESET;
      end
    end else begin
      ivl_mem_reg <= ivl_mem_next;
    end
  end

  // ==========================================================
  // run sequence: state, interval value, table index and the ramp-end pulse
  // start is taken only from idle, but a start held high while running flushes the pattern fifo every cycle
  assign take_start = (state_reg == ST_IDLE) && START && !STOP;
  assign load_ivl = (state_reg == ST_RAMP) && expiry;
  // a ramp of one entry or less is over at the start itself
  assign ramp_end = take_start ? (last_idx == '0) : (load_ivl && (idx_reg == last_idx));

  always_comb begin
    state_next = state_reg;
    ivl_next = ivl_reg;
    idx_next = idx_reg;
    // a stop in the same cycle aborts the ramp, so no completion is reported for it
    done_next = ramp_end && !STOP;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_start) begin
          ivl_next = ivl_mem_reg[0];
          idx_next = LEN_W'(1);
          if (ramp_end) begin
            state_next = ST_CRUISE;
          end else begin
            state_next = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        // each ramp step loads the next table entry
        if (load_ivl) begin
          ivl_next = ivl_fetch;
          idx_next = idx_reg + LEN_W'(1);
          if (ramp_end) begin
            state_next = ST_CRUISE;
          end
        end
      end
      ST_CRUISE: begin
        // the last loaded interval is kept for good
        ivl_next = ivl_reg;
      end
    endcase
    // stop holds the pins so the rotor keeps its position
    if (STOP) begin
      state_next = ST_IDLE;
    end
  end

  // run state registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ivl_reg <= IVL_RESET;
      idx_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ivl_reg <= ivl_next;
      idx_reg <= idx_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // step interval timer: a prescaler makes the 1 us unit, the count spans the interval
  // the count is reloaded at the expiry itself, so the step spacing never drifts
  always_comb begin
    tick_next = tick_reg;
    count_next = count_reg;
    if (running) begin
      tick_next = (tick_reg == '0) ? TICK_LAST : tick_reg - TICK_W'(1);
      if (tick) begin
        count_next = count_reg - IVL_W'(1);
      end
    end
    if (take_start) begin
      tick_next = TICK_LAST;
      count_next = ivl_mem_reg[0];
    end else if (expiry) begin
      // ramp steps take the next table value, constant rate repeats the last one
      count_next = (state_reg == ST_CRUISE) ? ivl_reg : ivl_fetch;
    end
    // a restart always begins with a whole first unit
    if (STOP) begin
      tick_next = TICK_LAST;
    end
  end

  // timer registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tick_reg <= TICK_LAST;
      count_reg <= IVL_RESET;
    end else begin
      tick_reg <= tick_next;
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // phase channel walks the table from entry 0, wrapping after the last entry
  // it advances whenever the fifo has room, so in a flush cycle it moves on although the push is lost
  always_comb begin
    ptr_next = ptr_reg;
    if (take_start) begin
      ptr_next = '0;
    end else if (running && ph_if.push_ready) begin
      ptr_next = ptr_reg + PHASE_AW'(1);
    end
  end

  // table pointer register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // ==========================================================
  // pulse output unit, mode 0: the new pattern and the step pulse share one edge
  always_comb begin
    phase_out_next = phase_out_reg;
    step_next = expiry;
    under_next = 1'b0;
    steps_next = steps_reg;
    if (take_start) begin
      steps_next = '0;
    end
    if (expiry) begin
      steps_next = steps_reg + 16'h0001;
      if (ph_if.pop_valid) begin
        phase_out_next = ph_if.pop_data;
      end else begin
        under_next = 1'b1;                                          // pins hold the old pattern
      end
    end
  end

  // output registers; the pins keep their pattern through stop and idle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      phase_out_reg <= PHASE_OUT_RESET;
      step_reg <= 1'b0;
      under_reg <= 1'b0;
      steps_reg <= '0;
    end else begin
      phase_out_reg <= phase_out_next;
      step_reg <= step_next;
      under_reg <= under_next;
      steps_reg <= steps_next;
    end
  end

  // ==========================================================
  // outputs
  assign PHASE_OUT = phase_out_reg;
  assign STEP_PULSE = step_reg;
  assign RAMP_DONE = done_reg;
  assign RUNNING = running;
  assign CRUISING = (state_reg == ST_CRUISE);
  assign UNDERRUN = under_reg;
  assign STEP_COUNT = steps_reg;

endmodule

`default_nettype wire

/* stepper_monitor.sv */
// checker for the stepping motor sequencer, bound to its top module
// assumes one clock REF_CLK and the asynchronous reset RST
`default_nettype none

module stepper_monitor import stepper_pkg::*; (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // watched pins
  input wire logic START,
  input wire logic STOP,
  input wire logic [PHASE_W-1:0] PHASE_OUT,
  input wire logic STEP_PULSE,
  input wire logic RAMP_DONE,
  input wire logic RUNNING,
  input wire logic CRUISING,
  input wire logic [15:0] STEP_COUNT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // step sequence
  // steps are at least one interval unit apart, so eight quiet cycles is a cheap floor
  sequence quiet_gap;
    !STEP_PULSE [*8];
  endsequence
  a_pins_hold: assert property (!STEP_PULSE |-> $stable(PHASE_OUT))
    else $error("phase pins moved without a step");
  a_step_gap: assert property (STEP_PULSE |=> quiet_gap)
    else $error("steps too close together");
  a_count_up: assert property (STEP_PULSE |-> STEP_COUNT == $past(STEP_COUNT) + 16'h0001)
    else $error("step count did not advance by one");
  a_done_cruise: assert property (RAMP_DONE |-> CRUISING && RUNNING)
    else $error("ramp end without constant rate");
  a_cruise_keep: assert property (CRUISING && !STOP |=> CRUISING)
    else $error("constant rate left without stop");
  a_start_run: assert property (START && !STOP && !RUNNING |=> RUNNING)
    else $error("start not taken");
  a_stop_idle: assert property (STOP |=> !RUNNING && !CRUISING)
    else $error("stop not taken");
  a_idle_still: assert property (!RUNNING [*2] |-> !STEP_PULSE && !RAMP_DONE)
    else $error("step while idle");
endmodule

bind stepper_ramp_phase_sequencer stepper_monitor stepper_monitor_inst (.REF_CLK(REF_CLK), .RST(RST),
  .START(START), .STOP(STOP), .PHASE_OUT(PHASE_OUT), .STEP_PULSE(STEP_PULSE), .RAMP_DONE(RAMP_DONE),
  .RUNNING(RUNNING), .CRUISING(CRUISING), .STEP_COUNT(STEP_COUNT));

`default_nettype wire

/* motor_stage.sv */
// model of the four-phase driver stage: counts coil pattern changes
// assumes the coil pins are registered on the same clock
`default_nettype none

module motor_stage import stepper_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // coil drive
  input wire logic [PHASE_W-1:0] coils,
  output logic [15:0] moves
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PHASE_W-1:0] last_reg;
  // each change of pattern is one rotor move; a repeated pattern does not move it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg <= PHASE_OUT_RESET;
      moves <= 16'h0000;
    end else if (coils !== last_reg) begin
      last_reg <= coils;
      moves <= moves + 16'h0001;
    end
  end
endmodule

`default_nettype wire

/* stepper_ramp_phase_sequencer_tb.sv */
// testbench for the stepping motor sequencer with its driver stage model
// assumes a 100 MHz clock and reset held for six cycles
`default_nettype none

module stepper_ramp_phase_sequencer_tb import stepper_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, start, stop, preset, half_step, tbl_wr, tbl_sel;
  logic [LEN_W-1:0] ramp_len;
  logic [IVL_AW-1:0] tbl_addr;
  logic [IVL_W-1:0] tbl_data;
  logic [PHASE_W-1:0] phase_out;
  logic step_pulse, ramp_done, running, cruising, underrun;
  logic [15:0] step_count, moves;
  int fails = 0;
  int compares = 0;

  stepper_ramp_phase_sequencer stepper_ramp_phase_sequencer_inst (.REF_CLK(ref_clk), .RST(rst),
    .START(start), .STOP(stop), .RAMP_LEN(ramp_len), .PRESET(preset), .HALF_STEP(half_step),
    .TBL_WR(tbl_wr), .TBL_SEL(tbl_sel), .TBL_ADDR(tbl_addr), .TBL_DATA(tbl_data),
    .PHASE_OUT(phase_out), .STEP_PULSE(step_pulse), .RAMP_DONE(ramp_done), .RUNNING(running),
    .CRUISING(cruising), .UNDERRUN(underrun), .STEP_COUNT(step_count));
  motor_stage motor_stage_inst (.clk(ref_clk), .rst(rst), .coils(phase_out), .moves(moves));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic sel, input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk) {tbl_wr, tbl_sel, tbl_addr, tbl_data} <= {1'b1, sel, a, d};
    @(posedge ref_clk) tbl_wr <= 1'b0;
  endtask
  // pulses a control for one cycle; the design takes it at the second edge
  task automatic go(input bit is_stop);
    @(posedge ref_clk) if (is_stop) stop <= 1'b1; else start <= 1'b1;
    @(posedge ref_clk) {start, stop} <= 2'b00;
    @(negedge ref_clk);
  endtask
  // counts cycles to the next step pulse, bounded so a stall shows as a wrong gap
  task automatic wait_step(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (step_pulse !== 1'b1 && n < 2000);
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic reset_state();
    chk("phase", 16'h0000, 16'(phase_out));
    chk("count", 16'h0000, step_count);
    chk("flags", 16'h0000, 16'({running, cruising, underrun, step_pulse}));
    $display("test reset_state done");
  endtask
  // three-entry ramp 3,2,1 units, then constant rate on the two-phase set
  task automatic ramp_run();
    int n;
    wr(TBL_IVL, 4'h0, 16'h0003);
    wr(TBL_IVL, 4'h1, 16'h0002);
    wr(TBL_IVL, 4'h2, 16'h0001);
    ramp_len <= 5'h03;
    go(0);
    chk("running", 16'h0001, 16'(running));
    for (int k = 0; k < 10; k++) begin
      wait_step(n);
      chk("gap", 16'(k == 0 ? 300 : k == 1 ? 200 : 100), 16'(n));
      chk("phase", 16'(TWO_PHASE_TBL[k % 8]), 16'(phase_out));
      chk("count", 16'(k + 1), step_count);
      chk("done", 16'(k == 1), 16'(ramp_done));
      chk("cruise", 16'(k >= 1), 16'(cruising));
      chk("moves", 16'(k), moves);
      chk("underrun", 16'h0000, 16'(underrun));
    end
    go(1);
    chk("running", 16'h0000, 16'(running));
    $display("test ramp_run done");
  endtask
  // half-step preset with entry 0 rewritten, zero-length ramp, stop holds pins, restart
  task automatic half_run();
    int n;
    logic [PHASE_W-1:0] held;
    @(posedge ref_clk) {half_step, preset} <= 2'b11;
    @(posedge ref_clk) preset <= 1'b0;
    wr(TBL_PHASE, 4'h0, 16'h000A);
    ramp_len <= 5'h00;
    go(0);
    chk("done", 16'h0001, 16'({ramp_done, cruising} == 2'b11));
    for (int k = 0; k < 9; k++) begin
      wait_step(n);
      chk("gap", 16'd300, 16'(n));
      chk("phase", 16'(k % 8 == 0 ? 4'hA : HALF_STEP_TBL[k % 8]), 16'(phase_out));
    end
    held = phase_out;
    go(1);
    repeat (400) @(negedge ref_clk);
    chk("held", 16'(held), 16'(phase_out));
    go(0);
    wait_step(n);
    chk("phase", 16'h000A, 16'(phase_out));
    chk("count", 16'h0001, step_count);
    go(1);
    $display("test half_run done");
  endtask

  // ==========================================================
  // clock, run and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, start, stop, preset, half_step, tbl_wr, tbl_sel} = 7'h40;
    {ramp_len, tbl_addr, tbl_data} = '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    reset_state();
    ramp_run();
    half_run();
    close_out();
  end
  // the scenarios need under 8000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end
endmodule

`default_nettype wire
